// File: hdl/pmw_power_mode.sv
// Power-mode sequencer with deep-sleep wake-source register
`timescale 1ns/1ps
`include "pmw_params.svh"
// Notes on behaviour
// - Run is default, all domains on except the calendar, which follows its enable.
// - Idle/sleep/deep by instruction; battery by hardware.
// - Sleep halts peripherals except selected ones.
// - Calendar runs in all modes if enabled.
// - Pin-change in deep sleep sets bit 8.
// - Fault in deep sleep sets bit 7.
// - Deep watchdog timeout sets bit 4.
// - Calendar alarm in deep sleep sets bit 3.
// - Enabled master clear asserted in deep sleep sets bit 2.
// - Flags hardware-set, software read/write, reset zero.
// - Setting deep-sleep enable clears all flags; a flag set by a wake event in the same cycle stays set.
// - Unused wake bits read zero.
module pmw_power_mode (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire pmw_pkg::pmw_req_t req,
  output logic [15:0] rdata,
  // Power-mode entry: instruction code pulse, main-supply loss level
  input wire logic [1:0] instr_code,
  input wire logic instr_valid,
  input wire logic vbat_active,
  input wire logic wake_req,
  // Wake events and master-clear pin enable
  input wire pmw_pkg::pmw_evt_t evt,
  input wire logic master_clear_pin_pin_enabled,
  // Domain controls and mode
  output pmw_pkg::pmw_dom_t dom,
  output pmw_pkg::pmw_mode_t mode,
  // Interrupt
  output logic irq
);
  import pmw_pkg::*;

  pmw_mode_t mode_q; // Current mode
  pmw_mode_t mode_d; // Next mode
  logic [15:0] ctrl_q; // Deep-sleep control
  logic [15:0] wake_q; // Wake-source flags
  logic [15:0] scr0_q; // Scratch register 0
  logic [15:0] scr1_q; // Scratch register 1
  logic [3:0] ist_q; // Interrupt status
  logic [3:0] imsk_q; // Interrupt mask
  logic [15:0] rdata_q; // Read data
  logic irq_q; // Interrupt output
  pmw_dom_t dom_q; // Domain controls
  logic [15:0] wake_set; // Hardware set terms
  logic [3:0] ist_set; // Interrupt events
  logic deep_sleep_enable_bit_set; // Software sets deep-sleep enable
  logic in_deep; // Deep-sleep window
  logic [3:0] ist_d; // Next interrupt status
  logic [3:0] imsk_d; // Next interrupt mask
  logic ist_rd; // Status read strobe, clears the status

  // Register write decode
  function automatic logic wr_hit(input pmw_req_t r, input logic [3:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  assign in_deep = (mode_q == PMW_DEEP);
  assign ist_rd = req.rd && (req.addr == `PMW_OFF_IRQ_STAT);
  assign deep_sleep_enable_bit_set = wr_hit(req, `PMW_OFF_CTRL) && req.wdata[`PMW_CTRL_DEEP_SLEEP_ENABLE_BIT_BIT];

  // Wake-source set terms, only while in deep sleep
  always_comb
  begin
    wake_set = `PMW_RST_16;
    wake_set[`PMW_WAKE_PIN_BIT] = in_deep && evt.pin_change;
    wake_set[`PMW_WAKE_FLT_BIT] = in_deep && evt.fault;
    wake_set[`PMW_WAKE_WDT_BIT] = in_deep && evt.dwdt_timeout;
    wake_set[`PMW_WAKE_CAL_BIT] = in_deep && evt.cal_alarm;
    wake_set[`PMW_WAKE_MASTER_CLEAR_PIN_BIT] = in_deep && evt.master_clear_pin_assert && master_clear_pin_pin_enabled;
  end

  // Mode sequencing
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      PMW_RUN:
      begin
        // Hardware entry has priority over instructions
        if (vbat_active)
          mode_d = ctrl_q[`PMW_CTRL_CAL_EN_BIT] ? PMW_VBAT_CAL : PMW_VBAT;
        else if (instr_valid && instr_code == `PMW_INS_IDLE)
          mode_d = PMW_IDLE;
        else if (instr_valid && instr_code == `PMW_INS_SLEEP)
          mode_d = ctrl_q[`PMW_CTRL_RETENTION_REGULATOR_ENABLE_BIT] ? PMW_LV_SLEEP : PMW_SLEEP;
        else if (instr_valid && instr_code == `PMW_INS_DEEP)
          mode_d = ctrl_q[`PMW_CTRL_DEEP_SLEEP_ENABLE_BIT_BIT] ? PMW_DEEP : PMW_SLEEP;
      end
      PMW_IDLE, PMW_SLEEP, PMW_LV_SLEEP, PMW_DEEP:
      begin
        // Supply loss overrides, a wake returns to run
        if (vbat_active)
          mode_d = ctrl_q[`PMW_CTRL_CAL_EN_BIT] ? PMW_VBAT_CAL : PMW_VBAT;
        else if (wake_req || (in_deep && |wake_set))
          mode_d = PMW_RUN;
      end
      PMW_VBAT, PMW_VBAT_CAL:
      begin
        // Main supply back
        if (!vbat_active)
          mode_d = PMW_RUN;
      end
      default: mode_d = PMW_RUN;
    endcase
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      mode_q <= PMW_RUN;
    else
      mode_q <= mode_d;
  end

  // Domain controls per next mode
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      dom_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    else
    begin
      dom_q.core_en <= (mode_d == PMW_RUN);
      dom_q.periph_en <= (mode_d == PMW_RUN) || (mode_d == PMW_IDLE);
      // Selected peripherals keep running in both sleeps
      dom_q.sel_periph_en <= (mode_d == PMW_RUN) || (mode_d == PMW_IDLE) ||
        (((mode_d == PMW_SLEEP) || (mode_d == PMW_LV_SLEEP)) && ctrl_q[`PMW_CTRL_SELPER_BIT]);
      dom_q.ram_retain <= !((mode_d == PMW_DEEP) || (mode_d == PMW_VBAT) || (mode_d == PMW_VBAT_CAL));
      dom_q.cal_run <= ctrl_q[`PMW_CTRL_CAL_EN_BIT];
      dom_q.scratch_retain <= 1'b1;
    end
  end

  // Control register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= `PMW_RST_16;
    else if (wr_hit(req, `PMW_OFF_CTRL))
      ctrl_q <= req.wdata & `PMW_CTRL_MASK;
  end

  // Wake-source flags: set wins over software write and over the enable clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wake_q <= `PMW_RST_16;
    else if (deep_sleep_enable_bit_set)
      wake_q <= wake_set & `PMW_WAKE_MASK;
    else if (wr_hit(req, `PMW_OFF_WAKE))
      wake_q <= (req.wdata | wake_set) & `PMW_WAKE_MASK;
    else
      wake_q <= (wake_q | wake_set) & `PMW_WAKE_MASK;
  end

  // Scratch registers, kept in every mode
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scr0_q <= `PMW_RST_16;
      scr1_q <= `PMW_RST_16;
    end
    else
    begin
      if (wr_hit(req, `PMW_OFF_SCRATCH0))
        scr0_q <= req.wdata;
      if (wr_hit(req, `PMW_OFF_SCRATCH1))
        scr1_q <= req.wdata;
    end
  end

  // Interrupt events: wake flag set, entered deep, entered battery, back to run
  assign ist_set = {|wake_set, (mode_d == PMW_DEEP) && !in_deep,
    (mode_d == PMW_VBAT || mode_d == PMW_VBAT_CAL) && (mode_q != mode_d),
    (mode_d == PMW_RUN) && (mode_q != PMW_RUN)};

  // Next status and mask; an event in the read cycle survives the clear
  always_comb
  begin
    ist_d = ist_rd ? ist_set : (ist_q | ist_set);
    imsk_d = wr_hit(req, `PMW_OFF_IRQ_MASK) ? req.wdata[3:0] : imsk_q;
  end

  // Interrupt status, cleared by read, set wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ist_q <= `PMW_IRQ_MASK_RST;
    else
      ist_q <= ist_d;
  end

  // Interrupt mask
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      imsk_q <= `PMW_IRQ_MASK_RST;
    else
      imsk_q <= imsk_d;
  end

  // Interrupt output from next status and next mask, so it never lags a mask write
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= |(ist_d & imsk_d);
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= `PMW_RST_16;
    else if (req.rd)
    begin
      unique case (req.addr)
        `PMW_OFF_CTRL: rdata_q <= ctrl_q;
        `PMW_OFF_WAKE: rdata_q <= wake_q & `PMW_WAKE_MASK;
        `PMW_OFF_MODE: rdata_q <= {9'h000, mode_q};
        `PMW_OFF_IRQ_STAT: rdata_q <= {12'h000, ist_q};
        `PMW_OFF_IRQ_MASK: rdata_q <= {12'h000, imsk_q};
        `PMW_OFF_SCRATCH0: rdata_q <= scr0_q;
        `PMW_OFF_SCRATCH1: rdata_q <= scr1_q;
        default: rdata_q <= `PMW_RST_16;
      endcase
    end
    else
      rdata_q <= `PMW_RST_16;
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign dom = dom_q;
  assign mode = mode_q;

  // Pin-change, fault and watchdog events seen in deep sleep leave their flags set
  property p_pin_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (in_deep && evt.pin_change && !deep_sleep_enable_bit_set) |=> wake_q[`PMW_WAKE_PIN_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin-change flag not set");

  property p_fault_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (in_deep && evt.fault) |=> wake_q[`PMW_WAKE_FLT_BIT];
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault flag not set");

  property p_wdt_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (in_deep && evt.dwdt_timeout && !vbat_active) |=> wake_q[`PMW_WAKE_WDT_BIT] && mode_q == PMW_RUN;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog wake wrong");

  property p_cal_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (!in_deep && !wake_q[`PMW_WAKE_CAL_BIT] && !wr_hit(req, `PMW_OFF_WAKE)) |=> !wake_q[`PMW_WAKE_CAL_BIT];
  endproperty
  a_cal_flag: assert property (p_cal_flag) else $error("calendar flag set outside deep sleep");

  property p_master_clear_pin_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (!master_clear_pin_pin_enabled && !wake_q[`PMW_WAKE_MASTER_CLEAR_PIN_BIT] && !wr_hit(req, `PMW_OFF_WAKE))
        |=> !wake_q[`PMW_WAKE_MASTER_CLEAR_PIN_BIT];
  endproperty
  a_master_clear_pin_flag: assert property (p_master_clear_pin_flag) else $error("master-clear flag set while disabled");

  property p_deep_sleep_enable_bit_clear;
    @(posedge clk_sys) disable iff (!rstn)
      (deep_sleep_enable_bit_set && !in_deep) |=> (wake_q == `PMW_RST_16);
  endproperty
  a_deep_sleep_enable_bit_clear: assert property (p_deep_sleep_enable_bit_clear) else $error("enable did not clear flags");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (!rstn)
      req.rd && req.addr == `PMW_OFF_WAKE |=> (rdata & ~`PMW_WAKE_MASK) == `PMW_RST_16;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused wake bits not zero");

  property p_instr_only;
    @(posedge clk_sys) disable iff (!rstn)
      (mode_q == PMW_RUN && !instr_valid && !vbat_active) |=> mode_q == PMW_RUN;
  endproperty
  a_instr_only: assert property (p_instr_only) else $error("left run without cause");

  property p_deep_dom;
    @(posedge clk_sys) disable iff (!rstn)
      mode_q == PMW_DEEP |-> !dom.ram_retain && !dom.core_en && !dom.periph_en;
  endproperty
  a_deep_dom: assert property (p_deep_dom) else $error("deep sleep domains wrong");

  property p_run_dom;
    @(posedge clk_sys) disable iff (!rstn)
      mode_q == PMW_RUN && $past(mode_q) == PMW_RUN |-> dom.core_en && dom.periph_en && dom.ram_retain;
  endproperty
  a_run_dom: assert property (p_run_dom) else $error("run domains wrong");

  property p_sleep_dom;
    @(posedge clk_sys) disable iff (!rstn)
      (mode_q == PMW_SLEEP || mode_q == PMW_LV_SLEEP) |-> !dom.periph_en;
  endproperty
  a_sleep_dom: assert property (p_sleep_dom) else $error("peripherals on in sleep");

  property p_cal_run;
    @(posedge clk_sys) disable iff (!rstn)
      ctrl_q[`PMW_CTRL_CAL_EN_BIT] |=> dom.cal_run;
  endproperty
  a_cal_run: assert property (p_cal_run) else $error("calendar stopped while enabled");

  property p_reset_zero;
    @(posedge clk_sys) $rose(rstn) |-> wake_q == `PMW_RST_16;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

  property p_vbat_entry;
    @(posedge clk_sys) disable iff (!rstn)
      vbat_active |=> (mode_q == PMW_VBAT) || (mode_q == PMW_VBAT_CAL);
  endproperty
  a_vbat_entry: assert property (p_vbat_entry) else $error("backup supply did not force battery mode");

  property p_idle_dom;
    @(posedge clk_sys) disable iff (!rstn)
      mode_q == PMW_IDLE |-> !dom.core_en && dom.periph_en && dom.ram_retain;
  endproperty
  a_idle_dom: assert property (p_idle_dom) else $error("idle domains wrong");

  property p_deep_needs_enable;
    @(posedge clk_sys) disable iff (!rstn)
      (mode_q != PMW_DEEP && !ctrl_q[`PMW_CTRL_DEEP_SLEEP_ENABLE_BIT_BIT]) |=> mode_q != PMW_DEEP;
  endproperty
  a_deep_needs_enable: assert property (p_deep_needs_enable) else $error("deep sleep without enable");
endmodule

// File: hdl/pmw_params.svh
// Register offsets, field positions, reset values and encodings of the power-mode block
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH
`define PMW_ADDR_W 4
`define PMW_OFF_CTRL 4'h0
`define PMW_OFF_WAKE 4'h1
`define PMW_OFF_MODE 4'h2
`define PMW_OFF_IRQ_STAT 4'h3
`define PMW_OFF_IRQ_MASK 4'h4
`define PMW_OFF_SCRATCH0 4'h5
`define PMW_OFF_SCRATCH1 4'h6
`define PMW_CTRL_DEEP_SLEEP_ENABLE_BIT_BIT 15
`define PMW_CTRL_RETENTION_REGULATOR_ENABLE_BIT 0
`define PMW_CTRL_CAL_EN_BIT 1
`define PMW_CTRL_SELPER_BIT 2
`define PMW_WAKE_PIN_BIT 8
`define PMW_WAKE_FLT_BIT 7
`define PMW_WAKE_WDT_BIT 4
`define PMW_WAKE_CAL_BIT 3
`define PMW_WAKE_MASTER_CLEAR_PIN_BIT 2
`define PMW_WAKE_MASK 16'h019c
`define PMW_CTRL_MASK 16'h8007
`define PMW_RST_16 16'h0000
`define PMW_IRQ_W 4
`define PMW_IRQ_MASK_RST 4'h0
`define PMW_INS_IDLE 2'h1
`define PMW_INS_SLEEP 2'h2
`define PMW_INS_DEEP 2'h3
`endif

// File: hdl/pmw_pkg.sv
// Types shared by the power-mode and wake-source block
package pmw_pkg;
  // Operating modes, one-hot
  typedef enum logic [6:0] {
    PMW_RUN = 7'b0000001,
    PMW_IDLE = 7'b0000010,
    PMW_SLEEP = 7'b0000100,
    PMW_LV_SLEEP = 7'b0001000,
    PMW_DEEP = 7'b0010000,
    PMW_VBAT = 7'b0100000,
    PMW_VBAT_CAL = 7'b1000000
  } pmw_mode_t;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pmw_req_t;
  // Deep-sleep wake events, one-cycle pulses
  typedef struct packed {
    logic pin_change;
    logic fault;
    logic dwdt_timeout;
    logic cal_alarm;
    logic master_clear_pin_assert;
  } pmw_evt_t;
  // Domain enables shown to the chip
  typedef struct packed {
    logic core_en;
    logic periph_en;
    logic sel_periph_en;
    logic ram_retain;
    logic cal_run;
    logic scratch_retain;
  } pmw_dom_t;
endpackage

// File: tb/pmw_power_mode_tb.sv
// Self-checking bench for the power-mode and wake-source block
`timescale 1ns/1ps
`include "pmw_params.svh"
module pmw_power_mode_tb;
  import pmw_pkg::*;
  // Clock, reset and stimulus
  logic clk_sys;
  logic rstn;
  pmw_req_t req;
  logic [1:0] instr_code;
  logic instr_valid;
  logic vbat_active;
  logic wake_req;
  pmw_evt_t evt;
  logic master_clear_pin_pin_enabled;
  // Observed outputs
  logic [15:0] rdata;
  pmw_dom_t dom;
  pmw_mode_t mode;
  logic irq;
  // Scoreboard
  int mismatches;
  int tests_run;
  logic [15:0] rd_val;

  pmw_power_mode u_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .req(req),
    .rdata(rdata),
    .instr_code(instr_code),
    .instr_valid(instr_valid),
    .vbat_active(vbat_active),
    .wake_req(wake_req),
    .evt(evt),
    .master_clear_pin_pin_enabled(master_clear_pin_pin_enabled),
    .dom(dom),
    .mode(mode),
    .irq(irq)
  );

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Register read result check
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Output pin check, values zero-extended
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Pulses of the instruction, wake and event inputs
  task automatic do_instr(input logic [1:0] c);
    @(posedge clk_sys);
    instr_code <= c;
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic do_wake();
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    #1;
  endtask
  task automatic do_evt(input logic [4:0] e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= 5'h00;
    #1;
  endtask

  // Asynchronous reset held two cycles, backup supply dropped
  task automatic apply_reset();
    rstn <= 1'b0;
    vbat_active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
  endtask

  // Values right after reset
  task automatic t_reset();
    chk_pin(mode, PMW_RUN);
    chk_pin(dom, 6'b111101);
    chk_pin(irq, 1'b0);
    reg_rd(`PMW_OFF_WAKE, rd_val);
    chk_reg(rd_val, 16'h0000);
  endtask

  // Each wake event in deep sleep sets its own flag only
  task automatic t_events();
    logic [15:0] exp_bit [5] = '{16'h0100, 16'h0080, 16'h0010, 16'h0008, 16'h0004};
    @(posedge clk_sys);
    master_clear_pin_pin_enabled <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(`PMW_OFF_CTRL, 16'h8000);
      do_instr(`PMW_INS_DEEP);
      chk_pin(mode, PMW_DEEP);
      chk_pin(dom, 6'b000001);
      do_evt(5'b10000 >> i);
      chk_pin(mode, PMW_RUN);
      reg_rd(`PMW_OFF_WAKE, rd_val);
      chk_reg(rd_val, exp_bit[i]);
    end
    // Master clear with the pin disabled, and a fault outside deep sleep
    reg_wr(`PMW_OFF_CTRL, 16'h8000);
    master_clear_pin_pin_enabled <= 1'b0;
    do_instr(`PMW_INS_DEEP);
    do_evt(5'b00001);
    chk_pin(mode, PMW_DEEP);
    do_wake();
    do_evt(5'b01000);
    reg_rd(`PMW_OFF_WAKE, rd_val);
    chk_reg(rd_val, 16'h0000);
  endtask

  // Software access, unused bits, read-only and unmapped places
  task automatic t_regs();
    reg_wr(`PMW_OFF_WAKE, 16'hffff);
    reg_rd(`PMW_OFF_WAKE, rd_val);
    chk_reg(rd_val, `PMW_WAKE_MASK);
    reg_wr(`PMW_OFF_CTRL, 16'h8000);
    reg_rd(`PMW_OFF_WAKE, rd_val);
    chk_reg(rd_val, 16'h0000);
    reg_wr(`PMW_OFF_WAKE, 16'h0084);
    reg_wr(`PMW_OFF_WAKE, 16'h0004);
    reg_rd(`PMW_OFF_WAKE, rd_val);
    chk_reg(rd_val, 16'h0004);
    reg_wr(`PMW_OFF_CTRL, 16'hffff);
    reg_rd(`PMW_OFF_CTRL, rd_val);
    chk_reg(rd_val, `PMW_CTRL_MASK);
    reg_wr(`PMW_OFF_SCRATCH1, 16'h3c5a);
    reg_rd(`PMW_OFF_SCRATCH1, rd_val);
    chk_reg(rd_val, 16'h3c5a);
    reg_wr(`PMW_OFF_IRQ_MASK, 16'hffff);
    reg_rd(`PMW_OFF_IRQ_MASK, rd_val);
    chk_reg(rd_val, 16'h000f);
    reg_wr(`PMW_OFF_IRQ_MASK, 16'h0000);
    reg_wr(`PMW_OFF_MODE, 16'h0010);
    reg_rd(`PMW_OFF_MODE, rd_val);
    chk_reg(rd_val, 16'h0001);
    reg_wr(`PMW_OFF_SCRATCH0, 16'ha5c3);
    reg_rd(`PMW_OFF_SCRATCH0, rd_val);
    chk_reg(rd_val, 16'ha5c3);
    reg_rd(4'hf, rd_val);
    chk_reg(rd_val, 16'h0000);
  endtask

  // Idle, sleep variants, refused deep entry and calendar domain
  task automatic t_modes();
    reg_wr(`PMW_OFF_CTRL, 16'h0000);
    do_instr(`PMW_INS_IDLE);
    chk_pin(mode, PMW_IDLE);
    chk_pin({dom.core_en, dom.periph_en}, 2'b01);
    do_wake();
    reg_wr(`PMW_OFF_CTRL, 16'h0006);
    do_instr(`PMW_INS_SLEEP);
    chk_pin(mode, PMW_SLEEP);
    chk_pin(dom, 6'b001111);
    do_instr(`PMW_INS_IDLE);
    chk_pin(mode, PMW_SLEEP);
    do_wake();
    reg_wr(`PMW_OFF_CTRL, 16'h0001);
    do_instr(`PMW_INS_SLEEP);
    chk_pin(mode, PMW_LV_SLEEP);
    do_wake();
    reg_wr(`PMW_OFF_CTRL, 16'h0000);
    do_instr(`PMW_INS_DEEP);
    chk_pin(mode, PMW_SLEEP);
    do_wake();
    reg_wr(`PMW_OFF_CTRL, 16'h8002);
    do_instr(`PMW_INS_DEEP);
    chk_pin(dom, 6'b000011);
    do_wake();
  endtask

  // Hardware entry to battery mode, with and without calendar
  task automatic t_vbat();
    reg_wr(`PMW_OFF_CTRL, 16'h0002);
    do_instr(`PMW_INS_SLEEP);
    chk_pin(mode, PMW_SLEEP);
    @(posedge clk_sys);
    vbat_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(mode, PMW_VBAT_CAL);
    chk_pin(dom, 6'b000011);
    @(posedge clk_sys);
    vbat_active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(mode, PMW_RUN);
    apply_reset();
    chk_pin(mode, PMW_RUN);
    @(posedge clk_sys);
    vbat_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(mode, PMW_VBAT);
    apply_reset();
  endtask

  // Interrupt raised when unmasked, cleared by status read, silent when masked
  task automatic t_irq();
    reg_rd(`PMW_OFF_IRQ_STAT, rd_val);
    reg_wr(`PMW_OFF_IRQ_MASK, 16'h0008);
    reg_wr(`PMW_OFF_CTRL, 16'h8000);
    do_instr(`PMW_INS_DEEP);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(irq, 1'b0);
    do_evt(5'b01000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(irq, 1'b1);
    reg_rd(`PMW_OFF_IRQ_STAT, rd_val);
    chk_reg(rd_val, 16'h000d);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(irq, 1'b0);
    reg_wr(`PMW_OFF_IRQ_MASK, 16'h0000);
    reg_wr(`PMW_OFF_CTRL, 16'h8000);
    do_instr(`PMW_INS_DEEP);
    do_evt(5'b01000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_pin(irq, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    mismatches = 0;
    tests_run = 0;
    rstn = 1'b0;
    req = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    instr_code = 2'h0;
    instr_valid = 1'b0;
    vbat_active = 1'b0;
    wake_req = 1'b0;
    evt = 5'h00;
    master_clear_pin_pin_enabled = 1'b0;
    apply_reset();
    t_reset();
    t_events();
    t_regs();
    t_modes();
    t_irq();
    t_vbat();
    complete_run();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
endmodule
